/* File: core_cfg.svh */
// Offsets, field positions, reset values and fixed codes for the execution core.
// Assumes a byte-addressed APB bus with 32-bit data and one word per register.
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// Register byte addresses
`define ADDR_W          8
`define REG_CMD         8'h00
`define REG_WORK        8'h04
`define REG_STATUS      8'h08
`define REG_CTRL        8'h0C
`define REG_FILE_ADDR   8'h10
`define REG_FILE_DATA   8'h14
`define REG_WDOG        8'h18

// Command word fields
`define CMD_OP_LSB      0
`define CMD_OP_MSB      2
`define CMD_DSEL_BIT    3
`define CMD_ADDR_LSB    4
`define CMD_ADDR_MSB    10

// Status word fields
`define ST_ZERO_BIT     0
`define ST_CARRY_BIT    1
`define ST_TO_BIT       2
`define ST_PD_BIT       3
`define ST_BUSY_BIT     4
`define ST_SKIP_BIT     5

// Control word fields
`define CTRL_PSC_WDT_BIT 0

// Watchdog readback fields
`define WD_CNT_LSB      0
`define WD_PSC_LSB      8

// Byte, word, nibble and nine-bit constants
`define BYTE_ZERO       8'h00
`define BYTE_ONE        8'h01
`define BYTE_FULL       8'hFF
`define WORD_ZERO       32'h0000_0000
`define NIB_LIMIT       4'h9
`define NIB_FIX         8'h06
`define HIGH_FIX        8'h60
`define BCD_LIMIT       9'h099

// Reset values
`define RST_FLAG_N      1'b1
`define RST_PSC_WDT     1'b0

`endif

/* File: core_pkg.sv */
// Types shared by the execution core, its operation unit and their carrier.
// Assumes core_cfg.svh is on the include path.
`include "core_cfg.svh"

package core_pkg;

	// Operation codes in the command word
	typedef enum logic [2:0] {
		OP_NOP,
		OP_CLEAR,
		OP_INVERT,
		OP_WDOG_CLEAR,
		OP_COMPARE,
		OP_DEC_ADJUST,
		OP_DEC_SKIP
	} op_e;

	// Instruction cycle sequencing
	typedef enum logic [1:0] {
		EX_IDLE,
		EX_RUN,
		EX_SKIP
	} exec_e;

	// Whole state of the execution core
	typedef struct packed {
		exec_e             st;
		op_e               op;
		logic              dsel;
		logic [6:0]        cmd_addr;
		logic [7:0]        work;
		logic              zero;
		logic              carry;
		logic              to_n;
		logic              pd_n;
		logic              skipped;
		logic              psc_wdt;
		logic [6:0]        file_addr;
		logic [7:0]        wdog;
		logic [7:0]        psc;
		logic [127:0][7:0] file;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} core_s;

endpackage : core_pkg

/* File: alu_if.sv */
// Carrier between the execution core and its operation unit.
// Assumes core_pkg is compiled first.
interface alu_if;
	import core_pkg::*;

	op_e        op;
	logic [7:0] fval;
	logic [7:0] work;
	logic       c_in;
	logic [7:0] res;
	logic       z;
	logic       c;

	modport core (output op, output fval, output work, output c_in,
		input res, input z, input c);
	modport alu (input op, input fval, input work, input c_in,
		output res, output z, output c);

endinterface : alu_if

/* File: op_alu.sv */
// Combinational operation unit: result byte, zero and carry for one operation.
// Assumes the core holds operands steady for the whole instruction cycle.
module op_alu (
	alu_if.alu bus
);
	import core_pkg::*;

	logic [8:0] diff;
	logic [8:0] adj;
	logic       lo_fix;
	logic       hi_fix;

	// Result and flag generation
	always_comb begin
		diff   = {1'b0, bus.fval} - {1'b0, bus.work};
		lo_fix = (bus.work[3:0] > `NIB_LIMIT);
		adj    = {1'b0, bus.work} + (lo_fix ? {1'b0, `NIB_FIX} : 9'h000);
		hi_fix = bus.c_in || (adj > `BCD_LIMIT) || adj[8];
		bus.res = `BYTE_ZERO;
		bus.c   = bus.c_in;
		case (bus.op)
			OP_INVERT: begin
				bus.res = ~bus.fval;
			end
			OP_COMPARE: begin
				bus.res = diff[7:0];
				bus.c   = ~diff[8];
			end
			OP_DEC_ADJUST: begin
				bus.res = adj[7:0] + (hi_fix ? `HIGH_FIX : `BYTE_ZERO);
				bus.c   = hi_fix;
			end
			OP_DEC_SKIP: begin
				bus.res = bus.fval - `BYTE_ONE;
			end
			default: begin
				bus.res = `BYTE_ZERO;
			end
		endcase
		bus.z = (bus.res == `BYTE_ZERO);
	end

endmodule : op_alu

/* File: instr_exec_core.sv */
// Execution core for clear, complement, watchdog clear, compare, decimal
// adjust and decrement-skip operations on a 128-byte file and work register.
// Assumes an APB master; one clock edge is one instruction cycle.
//
// Functional notes
// - Clear writes zero to the addressed file byte and sets zero flag in one cycle.
// - Complement inverts the file byte into work (d=0) or back (d=1), updating zero.
// - Watchdog clear zeroes the watchdog counter and sets timeout and power-down flags.
// - Watchdog clear also zeroes the prescaler only while it serves the watchdog.
// - Compare forms file minus work, updates zero and carry, and changes neither operand.
// - Decimal adjust turns work into packed decimal, touching only carry, in one cycle.
// - Decrement-skip subtracts one and writes work (d=0) or the file byte (d=1).
// - A zero decrement result discards the next instruction, taking two cycles.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
module instr_exec_core (
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	import core_pkg::*;

	core_s      s_reg;
	core_s      s_next;
	alu_if      alu_bus ();
	logic       access;
	logic       wdog_tick;
	logic       wd_overflow;
	logic       core_idle;
	op_e        cmd_op;
	logic       cmd_dsel;
	logic [6:0] cmd_addr;
	logic [7:0] fval;
	logic [7:0] file_rd;

	// Operation unit
	op_alu u_alu (
		.bus (alu_bus.alu)
	);

	// Operand feed from the latched command
	always_comb begin
		fval          = s_reg.file[s_reg.cmd_addr];
		file_rd       = s_reg.file[s_reg.file_addr];
		alu_bus.op    = s_reg.op;
		alu_bus.fval  = fval;
		alu_bus.work  = s_reg.work;
		alu_bus.c_in  = s_reg.carry;
	end

	// Bus outputs straight from state flops
	assign PRDATA  = s_reg.prdata;
	assign PREADY  = s_reg.pready;
	assign PSLVERR = s_reg.pslverr;

	// Watchdog tick source: every clock on timer, on wrap when prescaled
	always_comb begin
		if (s_reg.psc_wdt) begin
			wdog_tick = (s_reg.psc == `BYTE_FULL);
		end else begin
			wdog_tick = 1'b1;
		end
		wd_overflow = wdog_tick && (s_reg.wdog == `BYTE_FULL);
	end

	// Command fields and sequencer idle decode
	always_comb begin
		cmd_op    = op_e'(PWDATA[`CMD_OP_MSB:`CMD_OP_LSB]);
		cmd_dsel  = PWDATA[`CMD_DSEL_BIT];
		cmd_addr  = PWDATA[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
		core_idle = (s_reg.st == EX_IDLE);
	end

	// Next state: timekeeping, bus slave, then instruction execution
	always_comb begin
		// Hold by default; bus answers are one-cycle pulses
		s_next         = s_reg;
		s_next.pready  = 1'b0;
		s_next.pslverr = 1'b0;
		access         = PSEL && PENABLE && !s_reg.pready;

		// Prescaler runs freely; watchdog counts on its tick
		s_next.psc = s_reg.psc + `BYTE_ONE;
		if (wdog_tick) begin
			s_next.wdog = s_reg.wdog + `BYTE_ONE;
		end
		if (wd_overflow) begin
			s_next.to_n = 1'b0; // Watchdog overflow
		end

		// APB slave: answer one cycle after the access phase opens
		if (access) begin
			s_next.prdata = `WORD_ZERO;
			case (PADDR)
				// Command: latch and start only while the sequencer is idle
				`REG_CMD: begin
					if (PWRITE) begin
						// Command waits while an instruction is in flight
						if (core_idle) begin
							s_next.pready   = 1'b1;
							s_next.op       = cmd_op;
							s_next.dsel     = cmd_dsel;
							s_next.cmd_addr = cmd_addr;
							s_next.st       = EX_RUN;
						end
					end else begin
						s_next.pready = 1'b1;
						s_next.prdata[`CMD_OP_MSB:`CMD_OP_LSB]     = s_reg.op;
						s_next.prdata[`CMD_DSEL_BIT]               = s_reg.dsel;
						s_next.prdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB] = s_reg.cmd_addr;
					end
				end

				// Work register, byte wide
				`REG_WORK: begin
					s_next.pready = 1'b1;
					if (PWRITE) begin
						s_next.work = PWDATA[7:0];
					end else begin
						s_next.prdata[7:0] = s_reg.work;
					end
				end

				// Status: zero and carry writable, the rest read only
				`REG_STATUS: begin
					s_next.pready = 1'b1;
					if (PWRITE) begin
						s_next.zero  = PWDATA[`ST_ZERO_BIT];
						s_next.carry = PWDATA[`ST_CARRY_BIT];
					end else begin
						s_next.prdata[`ST_ZERO_BIT]  = s_reg.zero;
						s_next.prdata[`ST_CARRY_BIT] = s_reg.carry;
						s_next.prdata[`ST_TO_BIT]    = s_reg.to_n;
						s_next.prdata[`ST_PD_BIT]    = s_reg.pd_n;
						s_next.prdata[`ST_BUSY_BIT]  = !core_idle;
						s_next.prdata[`ST_SKIP_BIT]  = s_reg.skipped;
					end
				end

				// Control: prescaler assignment
				`REG_CTRL: begin
					s_next.pready = 1'b1;
					if (PWRITE) begin
						s_next.psc_wdt = PWDATA[`CTRL_PSC_WDT_BIT];
					end else begin
						s_next.prdata[`CTRL_PSC_WDT_BIT] = s_reg.psc_wdt;
					end
				end

				// File pointer for software access
				`REG_FILE_ADDR: begin
					s_next.pready = 1'b1;
					if (PWRITE) begin
						s_next.file_addr = PWDATA[6:0];
					end else begin
						s_next.prdata[6:0] = s_reg.file_addr;
					end
				end

				// File byte at the pointer
				`REG_FILE_DATA: begin
					s_next.pready = 1'b1;
					if (PWRITE) begin
						s_next.file[s_reg.file_addr] = PWDATA[7:0];
					end else begin
						s_next.prdata[7:0] = file_rd;
					end
				end

				// Watchdog and prescaler readback; writes ignored
				`REG_WDOG: begin
					s_next.pready = 1'b1;
					if (!PWRITE) begin
						s_next.prdata[`WD_CNT_LSB +: 8] = s_reg.wdog;
						s_next.prdata[`WD_PSC_LSB +: 8] = s_reg.psc;
					end
				end

				default: begin
					// Unmapped: error answer, reads zero
					s_next.pready  = 1'b1;
					s_next.pslverr = 1'b1;
				end
			endcase
		end

		// Instruction execution; overrides same-cycle software writes
		case (s_reg.st)
			// Waiting for a command
			EX_IDLE: begin
				s_next.st = s_next.st;
			end

			// Execute the latched command in one cycle
			EX_RUN: begin
				s_next.st      = EX_IDLE;
				s_next.skipped = 1'b0;
				// One-cycle operations, except decrement-skip with a zero result
				case (s_reg.op)
					// Clear file byte, force zero
					OP_CLEAR: begin
						s_next.file[s_reg.cmd_addr] = `BYTE_ZERO;
						s_next.zero                 = 1'b1;
					end

					// Complement to work or file
					OP_INVERT: begin
						if (s_reg.dsel) begin
							s_next.file[s_reg.cmd_addr] = alu_bus.res;
						end else begin
							s_next.work = alu_bus.res;
						end
						s_next.zero = alu_bus.z;
					end

					// Restart watchdog, restore both status flags
					OP_WDOG_CLEAR: begin
						s_next.wdog = `BYTE_ZERO;
						s_next.to_n = 1'b1;
						s_next.pd_n = 1'b1;
						if (s_reg.psc_wdt) begin
							s_next.psc = `BYTE_ZERO;
						end
					end

					// File minus work
					OP_COMPARE: begin
						// Operands untouched; flags only
						s_next.zero  = alu_bus.z;
						s_next.carry = alu_bus.c;
					end

					// Packed decimal correction of work
					OP_DEC_ADJUST: begin
						s_next.work  = alu_bus.res;
						s_next.carry = alu_bus.c;
					end

					// Decrement, skip the prefetch on zero
					OP_DEC_SKIP: begin
						if (s_reg.dsel) begin
							s_next.file[s_reg.cmd_addr] = alu_bus.res;
						end else begin
							s_next.work = alu_bus.res;
						end
						s_next.zero = alu_bus.z;
						if (alu_bus.z) begin
							// Discarded prefetch costs one extra cycle
							s_next.st      = EX_SKIP;
							s_next.skipped = 1'b1;
						end
					end

					// Spare codes act as no-operation
					default: begin
						s_next.st = EX_IDLE;
					end
				endcase
			end

			// Discarded prefetch slot
			EX_SKIP: begin
				s_next.st = EX_IDLE;
			end
			default: begin
				s_next.st = EX_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			// Sequencer and latched command
			s_reg.st        <= EX_IDLE;
			s_reg.op        <= OP_NOP;
			s_reg.dsel      <= 1'b0;
			s_reg.cmd_addr  <= '0;

			// Work register and status flags
			s_reg.work      <= `BYTE_ZERO;
			s_reg.zero      <= 1'b0;
			s_reg.carry     <= 1'b0;
			s_reg.to_n      <= `RST_FLAG_N;
			s_reg.pd_n      <= `RST_FLAG_N;
			s_reg.skipped   <= 1'b0;

			// Timekeeping, prescaler starts on the timer
			s_reg.psc_wdt   <= `RST_PSC_WDT;
			s_reg.wdog      <= `BYTE_ZERO;
			s_reg.psc       <= `BYTE_ZERO;

			// File and bus answer
			s_reg.file_addr <= '0;
			s_reg.file      <= '0;
			s_reg.pready    <= 1'b0;
			s_reg.pslverr   <= 1'b0;
			s_reg.prdata    <= `WORD_ZERO;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : instr_exec_core

/* File: instr_exec_core_properties.sv */
// APB port checker for the execution core.
// Assumes it is bound to instr_exec_core and sees only its ports.
module instr_exec_core_properties (
	input wire logic        CLOCK,
	input wire logic        RST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	// Access phase still waiting for its answer
	sequence s_wait;
		PSEL && PENABLE && !PREADY;
	endsequence

	// Completed read of one register
	sequence s_rd(a);
		PREADY && !PWRITE && PADDR == a;
	endsequence

	// Handshake shape
	AST_READY_ONE:
		assert property (PREADY |=> !PREADY) else $error("ready held too long");
	AST_READY_ACCESS:
		assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
	AST_ANSWER_BOUND:
		assert property (s_wait |-> ##[1:4] PREADY) else $error("answer too late");
	AST_ERR_READY:
		assert property (PSLVERR |-> PREADY) else $error("error without ready");
	// Address decoding
	AST_UNMAPPED:
		assert property (PREADY && PADDR > 8'h18 |-> PSLVERR) else $error("unmapped accepted");
	AST_MAPPED:
		assert property (PREADY && PADDR <= 8'h18 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
			else $error("mapped refused");
	// Unused upper read bits
	AST_STATUS_RD:
		assert property (s_rd(8'h08) |-> PRDATA[31:6] == 26'h0) else $error("status high bits");
	AST_WDOG_RD:
		assert property (s_rd(8'h18) |-> PRDATA[31:16] == 16'h0) else $error("watchdog high bits");
	AST_BYTE_RD:
		assert property (PREADY && !PWRITE && (PADDR == 8'h04 || PADDR == 8'h14)
			|-> PRDATA[31:8] == 24'h0) else $error("byte high bits");
endmodule : instr_exec_core_properties

bind instr_exec_core instr_exec_core_properties u_instr_exec_core_properties (.CLOCK, .RST_N,
	.PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);

/* File: instr_exec_core_tb.sv */
// Self-checking bench for the execution core with an integer reference model.
// Assumes the core executes a command on the edge after the one where its write is answered.
module instr_exec_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          bad_count, num_checks, seed, f, w, z, c, t, d, sk, op, adr, k, p, cyc;
	int          ops[7] = '{0, 1, 2, 4, 5, 6, 7};

	instr_exec_core u_instr_exec_core (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Free cycle count for elapsed-time expectations
	initial begin
		cyc = 0;
		forever @(posedge clock) cyc <= cyc + 1;
	end

	// One APB transfer, held until ready is sampled
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// Watchdog on the run
	initial begin
		repeat (6000) @(posedge clock);
		bad_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		seed = 43;
		bad_count = 0;
		num_checks = 0;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		bus(0, 8'h08, 0);
		chk("status", 32'h0000_000C, rd);
		bus(0, 8'h0C, 0);
		chk("ctrl", 32'h0000_0000, rd);
		$display("test reset done");
		// Random operands against the model
		for (k = 0; k < 35; k++) begin
			op = ops[k % 7];
			adr = $random(seed) & 127;
			w = $random(seed) & 255;
			f = (k % 3 == 0) ? ($random(seed) & 255) : ((k % 3 == 1) ? 1 : w);
			d = $random(seed) & 1;
			c = $random(seed) & 1;
			z = $random(seed) & 1;
			bus(1, 8'h10, adr);
			bus(1, 8'h14, f);
			bus(1, 8'h04, w);
			bus(1, 8'h08, c * 2 + z);
			bus(1, 8'h00, op + d * 8 + adr * 16);
			sk = 0;
			case (op)
				0, 7: begin
					sk = 0;
				end
				1: begin
					f = 0;
					z = 1;
				end
				2: begin
					t = ~f & 255;
					z = (t == 0);
				end
				4: begin
					z = (f == w);
					c = (f >= w);
				end
				5: begin
					c = (c || w > 153);
					w = (w + ((w & 15) > 9 ? 6 : 0) + (c ? 96 : 0)) & 255;
				end
				default: begin
					t = (f - 1) & 255;
					z = (t == 0);
					sk = z;
				end
			endcase
			if ((op == 2 || op == 6) && d)
				f = t;
			else if (op == 2 || op == 6)
				w = t;
			bus(0, 8'h04, 0);
			chk("work", w, rd);
			bus(0, 8'h14, 0);
			chk("file", f, rd);
			bus(0, 8'h08, 0);
			chk("flags", sk * 32 + c * 2 + z, rd & 32'h23);
		end
		$display("test operations done");
		// Overflow drops the timeout flag, clear restores it
		bus(1, 8'h0C, 0);
		repeat (300) @(posedge clock);
		bus(0, 8'h08, 0);
		chk("timeout", 0, rd & 4);
		// Prescaler on the timer survives a watchdog clear
		bus(0, 8'h18, 0);
		p = (rd >> 8) & 255;
		t = cyc;
		bus(1, 8'h00, 3);
		bus(0, 8'h18, 0);
		chk("psc_kept", (p + cyc - t) & 255, (rd >> 8) & 255);
		bus(1, 8'h0C, 1);
		bus(1, 8'h00, 3);
		bus(0, 8'h08, 0);
		chk("to_pd", 12, rd & 12);
		bus(0, 8'h18, 0);
		chk("wdog", 0, rd & 255);
		chk("psc", 1, (rd >> 8 & 255) < 16);
		$display("test watchdog done");
		// Unmapped places
		bus(1, 8'h40, 32'h0000_00FF);
		chk("err_wr", 1, er);
		bus(0, 8'h1C, 0);
		chk("err_rd", 1, er);
		chk("err_data", 0, rd);
		$display("test decode done");
		end_sim();
	end
endmodule : instr_exec_core_tb
